// [logic/tcc_comp.sv]
// Four-stage temperature compensation and output scaling pipeline.
// Assumes coefficients stay stable while samples are in flight.
module tcc_comp import tcc_pkg::*; (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   in_valid,
	input  wire tcc_sample_t            in_sample,
	input  wire tcc_coeff_t             coeff,
	output logic                        out_valid,
	output logic signed [OUT_W-1:0]     out_value
);
	// ------------------------------------------------------------
	// Pipeline registers
	// ------------------------------------------------------------
	logic [3:0]          vld_r;   // Stage valid chain
	logic signed [15:0]  h1_r, h2_r;
	logic signed [8:0]   dt_r;    // Temperature minus reference
	logic signed [10:0]  lc_r;    // Centred linear field
	logic signed [9:0]   qc_r;    // Centred quadratic field
	logic signed [27:0]  fac_r;   // Compensation factor, 23 fraction bits
	logic signed [43:0]  hf_r;    // Field times factor
	logic signed [7:0]   tref;    // Clamped reference temperature

	// Reference temperature held inside its adjustable span
	always_comb begin
		tref = 8'(coeff.tref);
		if (tref > TREF_MAX) begin
			tref = TREF_MAX;
		end else if (tref < TREF_MIN) begin
			tref = TREF_MIN;
		end
	end

	// Valid chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vld_r <= 4'h0;
		end else begin
			vld_r <= {vld_r[2:0], in_valid};
		end
	end

	// Stage 1: offsets of the coefficient codes and the temperature
	always_ff @(posedge pclk) begin
		h1_r <= in_sample.field;
		dt_r <= 9'(in_sample.temp) - 9'(tref);
		lc_r <= 11'($signed({2'b00, coeff.lin})) - LIN_ZERO;
		qc_r <= 10'($signed({2'b00, coeff.quad})) - QUAD_ZERO;
	end

	// Stage 2: factor = 1 + c1*dT + c2*dT^2, scaled by 2^23
	always_ff @(posedge pclk) begin
		h2_r  <= h1_r;
		fac_r <= (28'sd1 <<< FAC_FRAC)
			+ ((28'(lc_r) * 28'(dt_r)) <<< LIN_SHL)
			+ (28'(qc_r) * 28'(dt_r) * 28'(dt_r));
	end

	// Stage 3: field times compensation factor
	always_ff @(posedge pclk) begin
		hf_r <= 44'(h2_r) * 44'(fac_r);
	end

	// Stage 4: gain, doubling, 4096 scale and offset term
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_value <= '0;
		end else if (vld_r[2]) begin
			out_value <= OUT_W'((64'(hf_r) * 64'(17'($signed({2'b00, coeff.gain})) - GAIN_ZERO))
				>>> OUT_SHR) + OUT_W'(17'($signed({2'b00, coeff.ofs})) - OFS_ZERO);
		end
	end

	assign out_valid = vld_r[3];
endmodule // tcc_comp

// [logic/tcc_nvmem.sv]
// Nonvolatile calibration matrix, one row per word.
// Assumes the owner ignores read data of a row it writes in the same cycle.
module tcc_nvmem import tcc_pkg::*; #(
	parameter int DEPTH = NR
) (
	input  wire logic          pclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [RW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [RW-1:0] rdata
);
	// ------------------------------------------------------------
	// Storage, no reset: contents survive reset like the real cells
	// ------------------------------------------------------------
	logic [RW-1:0] mem [DEPTH];

	// Write port
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read port
	always_ff @(posedge pclk) begin
		rdata <= mem[raddr];
	end
endmodule // tcc_nvmem

// [logic/tcc_top.sv]
// Temperature compensation stage with its parity-protected calibration
// memory, RAM shadow, memory lock and APB register port.
// Assumes hall samples come from logic on pclk; APB master on pclk.
//
// Register access over APB and the placing of the registers are this design's own decisions.
module tcc_top import tcc_pkg::*; (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                sample_valid,
	input  wire tcc_sample_t         sample,
	output logic                     out_valid,
	output logic signed [OUT_W-1:0]  out_value,
	output logic                     out_drive_en,
	output logic                     prog_enable
);
	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_READ   = 6'b000010,
		ST_CHECK  = 6'b000100,
		ST_RUN    = 6'b001000,
		ST_COMMIT = 6'b010000,
		ST_DEAD   = 6'b100000
	} tcc_state_t;

	tcc_state_t     state_r;             // Load/commit sequencer
	logic [RW-1:0]  rows_r [NR];         // RAM shadow of the matrix
	logic [AW-1:0]  cnt_r;               // Row counter for load/commit
	logic [AW-1:0]  ridx_r;              // Row whose read data arrives
	logic           rvld_r;              // Read data valid this cycle
	logic [DROWS-1:0] rbad_r;            // Rows failing odd parity
	logic [RW-1:0]  colacc_r;            // Running column xor
	logic           loaded_r;            // Shadow valid
	logic           fixed_r;             // A single bit was repaired
	logic           fatal_r;             // Uncorrectable error seen
	logic           lock_r;              // Memory frozen
	logic signed [OUT_W-1:0] last_r;     // Last compensated result

	logic           acc_w;               // APB access phase
	logic           wr_ok;               // Write allowed to shadow
	logic           row_hit;             // Address hits a row register
	logic [AW-1:0]  row_sel;             // Row addressed by APB
	logic           mapped;              // Address decodes to a register
	logic           rej;                 // Write refused
	logic           nv_we;               // Commit write strobe
	logic [RW-1:0]  nv_rdata;            // Memory read data
	logic [AW-1:0]  nv_raddr;            // Memory read address
	logic [RW-1:0]  colbad;              // Columns with wrong parity
	logic [DROWS-1:0] rowbad_all;        // Row flags for checking
	int unsigned    nrow, ncol;          // Error counts
	logic [AW-1:0]  frow;                // Row to repair
	logic [4:0]     fcol;                // Column to repair
	tcc_coeff_t     coeff;               // Settings driving processing
	logic           cmp_valid;           // Pipeline result strobe
	logic signed [OUT_W-1:0] cmp_value;  // Pipeline result

	// ------------------------------------------------------------
	// Nonvolatile matrix
	// ------------------------------------------------------------
	assign nv_we    = (state_r == ST_COMMIT);
	assign nv_raddr = cnt_r;

	tcc_nvmem #(
		.DEPTH (NR)
	) u_nvmem (
		.pclk  (pclk),
		.we    (nv_we),
		.waddr (cnt_r),
		.wdata (rows_r[cnt_r]),
		.raddr (nv_raddr),
		.rdata (nv_rdata)
	);

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Zero wait states: every access finishes in its first access cycle
	assign pready  = 1'b1;
	assign acc_w   = psel && penable;
	assign row_hit = (paddr[1:0] == 2'b00) && (paddr >= A_ROW0)
		&& (paddr < A_ROW0 + 8'(4 * NR));
	assign row_sel = AW'((paddr - A_ROW0) >> 2);
	assign mapped  = row_hit || paddr == A_CTRL || paddr == A_STAT
		|| paddr == A_OUT || paddr == A_LIN || paddr == A_QUAD;
	// Shadow edits only while running and not frozen
	assign wr_ok   = (state_r == ST_RUN) && !lock_r;
	assign rej     = pwrite && (paddr != A_CTRL) && (paddr != A_STAT)
		&& (paddr != A_OUT) && !wr_ok;
	assign pslverr = acc_w && (!mapped || rej);

	// Read mux
	always_comb begin
		prdata = '0;
		if (row_hit) begin
			prdata = 32'(rows_r[row_sel]);
		end else begin
			unique case (paddr)
				A_STAT: begin
					prdata[S_LOADED] = loaded_r;
					prdata[S_FIXED]  = fixed_r;
					prdata[S_FATAL]  = fatal_r;
					prdata[S_LOCKED] = lock_r;
					prdata[S_BUSY]   = (state_r != ST_RUN) && (state_r != ST_DEAD);
				end
				A_OUT:  prdata = 32'(unsigned'(last_r));
				A_LIN:  prdata = 32'(rows_r[LIN_ROW][LIN_W-1:0]);
				A_QUAD: prdata = 32'(rows_r[QUAD_ROW][QUAD_W-1:0]);
				default: prdata = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Parity evaluation after the last row is read
	// ------------------------------------------------------------
	// Column parity: even bits even, odd bits odd, parity column even
	assign colbad     = colacc_r ^ COL_EXP;
	assign rowbad_all = rbad_r;

	// Count and locate failing rows and columns
	always_comb begin
		nrow = 0;
		ncol = 0;
		frow = '0;
		fcol = '0;
		for (int i = 0; i < DROWS; i++) begin
			if (rowbad_all[i]) begin
				nrow++;
				frow = AW'(i);
			end
		end
		for (int j = 0; j < RW; j++) begin
			if (colbad[j]) begin
				ncol++;
				fcol = 5'(j);
			end
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// Reload after reset; commit and reload on software request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					state_r <= ST_READ;
				end
				ST_READ: begin
					if (rvld_r && ridx_r == AW'(NR - 1)) begin
						state_r <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					// Fatal matrix locks the sequencer for good
					if (nrow > 1 || (nrow == 1 && ncol != 1) || (nrow == 0 && ncol > 1)) begin
						state_r <= ST_DEAD;
					end else begin
						state_r <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (acc_w && pwrite && paddr == A_CTRL && wr_ok) begin
						if (pwdata[C_COMMIT]) begin
							state_r <= ST_COMMIT;
						end else if (pwdata[C_RELOAD]) begin
							state_r <= ST_IDLE;
						end
					end
				end
				ST_COMMIT: begin
					if (cnt_r == AW'(NR - 1)) begin
						state_r <= ST_IDLE;
					end
				end
				ST_DEAD: begin
					state_r <= ST_DEAD;
				end
			endcase
		end
	end

	// Row counter for the memory walks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if ((state_r == ST_READ && cnt_r != AW'(NR - 1))
			|| (state_r == ST_COMMIT && cnt_r != AW'(NR - 1))) begin
			cnt_r <= cnt_r + 1'b1;
		end else if (state_r == ST_IDLE || state_r == ST_CHECK
			|| state_r == ST_COMMIT) begin
			cnt_r <= '0;
		end
	end

	// Read data tracking, one cycle behind the address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ridx_r <= '0;
			rvld_r <= 1'b0;
		end else begin
			ridx_r <= cnt_r;
			rvld_r <= (state_r == ST_READ) && !(rvld_r && ridx_r == AW'(NR - 1));
		end
	end

	// Parity accumulation while rows stream in
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rbad_r   <= '0;
			colacc_r <= '0;
		end else if (state_r == ST_IDLE) begin
			rbad_r   <= '0;
			colacc_r <= '0;
		end else if (state_r == ST_READ && rvld_r) begin
			colacc_r <= colacc_r ^ nv_rdata;
			if (ridx_r < AW'(DROWS)) begin
				rbad_r[ridx_r[2:0]] <= ~^nv_rdata;
			end
		end
	end

	// ------------------------------------------------------------
	// RAM shadow of the matrix
	// ------------------------------------------------------------
	// Loaded from memory, repaired, then edited by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NR; i++) begin
				rows_r[i] <= '0;
			end
		end else if (state_r == ST_READ && rvld_r) begin
			rows_r[ridx_r] <= nv_rdata;
		end else if (state_r == ST_CHECK && nrow == 1 && ncol == 1) begin
			rows_r[frow][fcol] <= ~rows_r[frow][fcol];
		end else if (acc_w && pwrite && wr_ok) begin
			// Trial settings stay volatile until a commit
			if (row_hit) begin
				rows_r[row_sel] <= pwdata[RW-1:0];
			end else if (paddr == A_LIN) begin
				rows_r[LIN_ROW][LIN_W-1:0] <= pwdata[LIN_W-1:0];
			end else if (paddr == A_QUAD) begin
				rows_r[QUAD_ROW][QUAD_W-1:0] <= pwdata[QUAD_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	// Loaded only after checking, so raw rows never drive processing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loaded_r <= 1'b0;
		end else if (state_r == ST_IDLE) begin
			loaded_r <= 1'b0;
		end else if (state_r == ST_CHECK) begin
			loaded_r <= 1'b1;
		end
	end

	// Repair flag, refreshed on each load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fixed_r <= 1'b0;
		end else if (state_r == ST_CHECK) begin
			fixed_r <= (nrow == 1 && ncol == 1);
		end
	end

	// Fatal flag is sticky until reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fatal_r <= 1'b0;
		end else if (state_r == ST_CHECK && (nrow > 1 || (nrow == 1 && ncol != 1)
			|| (nrow == 0 && ncol > 1))) begin
			fatal_r <= 1'b1;
		end
	end

	// Lock comes from the checked memory image; both bits required
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= 1'b0;
		end else if (state_r == ST_CHECK && nrow <= 1) begin
			lock_r <= lock_r || (&rows_r[LOCK_ROW][LOCK_W-1:0]);
		end
	end

	// ------------------------------------------------------------
	// Signal processing
	// ------------------------------------------------------------
	assign coeff = {rows_r[LIN_ROW][LIN_W-1:0],
		rows_r[QUAD_ROW][QUAD_W-1:0],
		rows_r[TREF_ROW][TREF_W-1:0],
		rows_r[GAIN_ROW][GAIN_W-1:0],
		rows_r[OFS_ROW][OFS_W-1:0]};

	tcc_comp u_comp (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (sample_valid && loaded_r && !fatal_r),
		.in_sample (sample),
		.coeff     (coeff),
		.out_valid (cmp_valid),
		.out_value (cmp_value)
	);

	// Output register, last result also readable by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r    <= '0;
			out_valid <= 1'b0;
		end else begin
			out_valid <= cmp_valid && !fatal_r;
			if (cmp_valid) begin
				last_r <= cmp_value;
			end
		end
	end

	assign out_value = last_r;
	// Driver stays off until good data, and off for ever after a fatal error
	assign out_drive_en = loaded_r && !fatal_r;
	// Programming port usable only while unlocked
	assign prog_enable  = !lock_r && !fatal_r;
endmodule // tcc_top

// [pkg/tcc_pkg.sv]
// Constants, field layout and carrier types of the temperature
// compensation and calibration memory block.
// Assumes a single 100 MHz pclk domain and an APB register port.
package tcc_pkg;
	// ------------------------------------------------------------
	// Calibration matrix geometry
	// ------------------------------------------------------------
	localparam int RW    = 17;          // Row width, bit 16 is row parity
	localparam int DROWS = 8;           // Data rows
	localparam int NR    = 9;           // Data rows plus column parity row
	localparam int AW    = 4;           // Row address width
	localparam int PB    = 16;          // Row parity bit position
	localparam logic [RW-1:0] COL_EXP = 17'h0AAAA; // Odd columns odd, rest even
	// ------------------------------------------------------------
	// Field placement inside rows
	// ------------------------------------------------------------
	localparam int LIN_ROW  = 0;  localparam int LIN_W  = 9;
	localparam int QUAD_ROW = 1;  localparam int QUAD_W = 8;
	localparam int OFS_ROW  = 2;  localparam int OFS_W  = 15;
	localparam int TREF_ROW = 3;  localparam int TREF_W = 8;
	localparam int GAIN_ROW = 4;  localparam int GAIN_W = 15;
	localparam int LOCK_ROW = 5;  localparam int LOCK_W = 2;
	// ------------------------------------------------------------
	// Arithmetic encodings
	// ------------------------------------------------------------
	localparam logic signed [10:0] LIN_ZERO  = 11'sh0A0;  // 160
	localparam logic signed [9:0]  QUAD_ZERO = 10'sh080;  // 128
	localparam logic signed [16:0] OFS_ZERO  = 17'sh04000; // 16384
	localparam logic signed [16:0] GAIN_ZERO = 17'sh04000; // 16384
	localparam logic signed [7:0]  TREF_MAX  = 8'sh40;    // 64 degC
	localparam logic signed [7:0]  TREF_MIN  = -8'sh30;   // -48 degC
	localparam int FAC_FRAC = 23;       // Factor scale 8388608
	localparam int LIN_SHL  = 7;        // 8388608 / 65536
	localparam int OUT_SHR  = 37;       // 15 hall + 23 fac + 12 gain - 12 - 1
	localparam int OUT_W    = 20;
	// ------------------------------------------------------------
	// Register byte addresses and status bits
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_OUT  = 8'h08;
	localparam logic [7:0] A_LIN  = 8'h0C;
	localparam logic [7:0] A_QUAD = 8'h10;
	localparam logic [7:0] A_ROW0 = 8'h20;
	localparam int C_COMMIT = 0;
	localparam int C_RELOAD = 1;
	localparam int S_LOADED = 0;
	localparam int S_FIXED  = 1;
	localparam int S_FATAL  = 2;
	localparam int S_LOCKED = 3;
	localparam int S_BUSY   = 4;
	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic signed [15:0] field;  // Normalised field, Q15
		logic signed [7:0]  temp;   // Junction temperature, degC
	} tcc_sample_t;
	typedef struct packed {
		logic [LIN_W-1:0]         lin;
		logic [QUAD_W-1:0]        quad;
		logic signed [TREF_W-1:0] tref;
		logic [GAIN_W-1:0]        gain;
		logic [OFS_W-1:0]         ofs;
	} tcc_coeff_t;
endpackage

// [testbench/tcc_prog_host.sv]
// Programming host model: APB master and calibration image builder.
// Assumes its tasks are entered just after a rising pclk edge.
module tcc_prog_host import tcc_pkg::*; (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel = 1'b0,
	output logic             penable = 1'b0,
	output logic             pwrite = 1'b0,
	output logic [7:0]       paddr = 8'h00,
	output logic [31:0]      pwdata = 32'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [RW-1:0] img [0:NR-1];  // Image being prepared
	logic          stalled = 1'b0; // Set if pready never came
	// Setup then access; request held until pready, then released
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge pclk);
		stalled = stalled | (n == 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;  // Stale address is not left on the bus
		pwdata <= ~d;
		@(posedge pclk);
	endtask
	// Row parity odd, then a column row making all rows xor to COL_EXP
	task automatic seal();
		logic [RW-1:0] col;
		col = COL_EXP;
		for (int i = 0; i < DROWS; i++) begin
			img[i][PB] = ~^img[i][PB-1:0];
			col = col ^ img[i];
		end
		img[DROWS] = col;
	endtask
	// Fresh image; factory rows hold arbitrary content
	task automatic build(input int lin, quad, ofs, tref, gain);
		img = '{default: '0};
		img[LIN_ROW] = RW'(lin);
		img[QUAD_ROW] = RW'(quad);
		img[OFS_ROW] = RW'(ofs);
		img[TREF_ROW] = RW'(tref);
		img[GAIN_ROW] = RW'(gain);
		img[6] = 17'h0135A;
		img[7] = 17'h00C3F;
		seal();
	endtask
	// Read back all data rows, factory ones too, set lock, reseal, write, commit
	task automatic lock_commit();
		logic [31:0] rd;
		logic        e;
		for (int i = 0; i < DROWS; i++) begin
			xfer(1'b0, A_ROW0 + 8'(4 * i), 32'h0, rd, e);
			img[i] = rd[RW-1:0];
		end
		img[LOCK_ROW][1:0] = 2'b11;
		seal();
		for (int i = 0; i < NR; i++) xfer(1'b1, A_ROW0 + 8'(4 * i), 32'(img[i]), rd, e);
		xfer(1'b1, A_CTRL, 32'h1, rd, e);
	endtask
endmodule // tcc_prog_host

// [testbench/tcc_top_monitor.sv]
// Port checker for the compensation and calibration memory block.
// Assumes one pclk domain and the APB map of tcc_pkg; bound into tcc_top.
module tcc_top_monitor import tcc_pkg::*; (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             prdata,
	input wire logic                    pslverr,
	input wire logic                    sample_valid,
	input wire logic                    out_valid,
	input wire logic signed [OUT_W-1:0] out_value,
	input wire logic                    out_drive_en,
	input wire logic                    prog_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------
	// Decode
	// ----------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_acc; // Read access phase
	logic wr_acc; // Write access phase
	assign rd_acc = psel && penable && !pwrite;
	assign wr_acc = psel && penable && pwrite;
	a_lin_width: assert property (rd_acc && paddr == A_LIN |-> prdata[31:9] == 23'h0)
		else $error("linear field reads wider than nine bits");
	a_quad_width: assert property (rd_acc && paddr == A_QUAD |-> prdata[31:8] == 24'h0)
		else $error("quadratic field reads wider than eight bits");
	a_out_latency: assert property (out_valid |-> $past(sample_valid, 5))
		else $error("result without a sample five cycles before");
	a_hold_value: assert property (!out_valid |-> $stable(out_value))
		else $error("result moved without out_valid");
	a_drop_dead: assert property (sample_valid && !out_drive_en |-> ##5 !out_valid)
		else $error("sample processed while driver off");
	a_fatal_off: assert property (rd_acc && paddr == A_STAT && prdata[S_FATAL]
		|-> !out_drive_en && !prog_enable) else $error("driver on after fatal error");
	a_lock_prog: assert property (rd_acc && paddr == A_STAT && prdata[S_LOCKED]
		|-> !prog_enable) else $error("programming open while locked");
	a_lock_refuse: assert property (wr_acc && !prog_enable && (paddr == A_LIN
		|| paddr == A_QUAD || paddr >= A_ROW0) |-> pslverr) else $error("locked write taken");
	a_lock_sticky: assert property ($fell(prog_enable) |-> !prog_enable [*8])
		else $error("programming reopened");
endmodule // tcc_top_monitor

bind tcc_top tcc_top_monitor tcc_top_monitor_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pslverr(pslverr), .sample_valid(sample_valid),
	.out_valid(out_valid), .out_value(out_value), .out_drive_en(out_drive_en),
	.prog_enable(prog_enable));

// [testbench/tcc_top_tb.sv]
// Self-checking bench for tcc_top with the programming host model.
// Assumes the host drives APB; samples are driven here on pclk.
module tcc_top_tb import tcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic               pclk = 1'b0;    // 100 MHz
	logic               presetn = 1'b0; // Active low
	logic               psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic               sample_valid = 1'b0;
	tcc_sample_t        sample = '0;
	logic               out_valid, out_drive_en, prog_enable;
	logic signed [19:0] out_value;
	int                 fail_count = 0;
	int                 checked = 0;
	int                 lin = 170, quad = 120, ofs = 16084, tref = 64, gain = 18432;
	always #5 pclk = ~pclk;
	tcc_top tcc_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sample_valid), .sample(sample), .out_valid(out_valid),
		.out_value(out_value), .out_drive_en(out_drive_en), .prog_enable(prog_enable));
	tcc_prog_host tcc_prog_host_i (
		.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic give_up(input bit hit);
		if (hit) begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		tcc_prog_host_i.xfer(wr, a, d, rd, err);
		give_up(tcc_prog_host_i.stalled);
	endtask
	// Poll status until the load sequence has finished
	task automatic settle();
		int n;
		for (n = 0; n < 40; n++) begin
			bus(1'b0, A_STAT, 32'h0);
			if (rd[S_BUSY] === 1'b0 && (rd[S_LOADED] === 1'b1 || rd[S_FATAL] === 1'b1)) break;
		end
		give_up(n == 40);
	endtask
	// Reset with a sealed image preloaded; rows a and b get a flipped bit
	task automatic boot(input int a, input int b);
		presetn <= 1'b0;
		tcc_prog_host_i.build(lin, quad, ofs, tref, gain);
		for (int i = 0; i < NR; i++) tcc_top_i.u_nvmem.mem[i] = tcc_prog_host_i.img[i];
		if (a >= 0) tcc_top_i.u_nvmem.mem[a][3] = ~tcc_prog_host_i.img[a][3];
		if (b >= 0) tcc_top_i.u_nvmem.mem[b][5] = ~tcc_prog_host_i.img[b][5];
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		settle();
	endtask
	// Reference polynomial; arithmetic shift truncates toward minus infinity
	function automatic logic [19:0] model(input int f, input int t);
		longint dt, fac;
		dt = t - tref;
		fac = (longint'(1) << 23) + ((lin - 160) * dt << 7) + (quad - 128) * dt * dt;
		return 20'(((f * fac * (gain - 16384)) >>> 37) + ofs - 16384);
	endfunction
	// Two back-to-back samples; results come out in order
	task automatic pair(input int f0, t0, f1, t1);
		int n;
		sample_valid <= 1'b1;
		sample <= {16'(f0), 8'(t0)};
		@(posedge pclk);
		sample <= {16'(f1), 8'(t1)};
		@(posedge pclk);
		sample_valid <= 1'b0;
		for (n = 0; n < 20 && out_valid !== 1'b1; n++) @(posedge pclk);
		give_up(n == 20);
		check("result a", {12'h0, out_value}, {12'h0, model(f0, t0)});
		@(posedge pclk);
		check("result b", {12'h0, out_value}, {12'h0, model(f1, t1)});
	endtask
	task automatic s_load();
		check("status", rd, 32'h1);
		check("drive", {31'h0, out_drive_en}, 32'h1);
		bus(1'b0, A_LIN, 32'h0);
		check("lin", rd, 32'(lin));
		pair(20000, 84, -12000, 14);
	endtask
	// Trial settings in the shadow, then reload from the untouched memory
	task automatic s_shadow();
		bus(1'b1, A_LIN, 32'hFFFF);
		bus(1'b0, A_LIN, 32'h0);
		check("lin wide", rd, 32'h1FF);
		bus(1'b1, A_QUAD, 32'hFFFF);
		bus(1'b0, A_QUAD, 32'h0);
		check("quad wide", rd, 32'hFF);
		lin = 511;
		quad = 255;
		pair(-32768, -128, 32767, 127);
		lin = 170;
		quad = 120;
		bus(1'b1, A_CTRL, 32'h2);
		settle();
		bus(1'b0, A_LIN, 32'h0);
		check("lin reload", rd, 32'(lin));
		bus(1'b0, 8'hFC, 32'h0);
		check("unmapped", {31'h0, err}, 32'h1);
	endtask
	task automatic s_fix();
		boot(2, -1);
		check("fixed", rd, 32'h3);
		bus(1'b0, A_ROW0 + 8'h08, 32'h0);
		check("row fixed", rd, 32'(tcc_prog_host_i.img[2]));
		pair(9000, 30, 0, 64);
	endtask
	task automatic s_lock();
		tcc_prog_host_i.lock_commit();
		settle();
		check("locked", rd & 32'h9, 32'h9);
		check("prog", {31'h0, prog_enable}, 32'h0);
		bus(1'b1, A_LIN, 32'h1);
		check("refused", {31'h0, err}, 32'h1);
		bus(1'b0, A_LIN, 32'h0);
		check("frozen", rd, 32'(lin));
		pair(-500, 100, 700, -40);
	endtask
	task automatic s_fatal();
		boot(0, 3);
		check("fatal", {31'h0, rd[S_FATAL]}, 32'h1);
		sample_valid <= 1'b1;
		@(posedge pclk);
		sample_valid <= 1'b0;
		repeat (8) begin
			@(posedge pclk);
			check("dropped", {30'h0, out_valid, out_drive_en}, 32'h0);
		end
	endtask
	initial begin
		#500000;
		give_up(1'b1);
	end
	initial begin
		boot(-1, -1);
		s_load();
		s_shadow();
		s_fix();
		s_lock();
		s_fatal();
		end_of_test();
	end
endmodule // tcc_top_tb
